// ==== verilog/lwm_pkg.sv ====
// Constants and types shared by the move-instruction execute logic
`default_nettype none
package lwm_pkg;
  // ==========================================================
  // Opcode fields
  localparam logic [7:0] OPC_BANK_LOAD = 8'h01;
  localparam logic [7:0] OPC_LIT_LOAD = 8'h0E;
  localparam logic [6:0] OPC_STORE = 7'h37;
  localparam int OPC_HI_MSB = 15;
  localparam int OPC_HI_LSB = 8;
  localparam int OPC_STORE_LSB = 9;
  localparam int ACCESS_BIT = 8;
  // ==========================================================
  // Addressing
  localparam logic [7:0] INDEX_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_HI_PAGE = 4'hF;
  localparam logic [3:0] ACCESS_LO_PAGE = 4'h0;
  localparam logic [3:0] BANK_HI_ZERO = 4'h0;
  localparam logic ACCESS_SEL_BANKED = 1'b1;
  // ==========================================================
  // Reset values
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic [15:0] INSTR_RESET = 16'h0000;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  // ==========================================================
  // Instruction phases
  typedef enum logic [3:0] {
    PH_DECODE = 4'h1,
    PH_READ = 4'h2,
    PH_PROCESS = 4'h4,
    PH_WRITE = 4'h8
  } lwm_phase_t;
endpackage : lwm_pkg
`default_nettype wire

// ==== verilog/lwm_dec_if.sv ====
// Decoded instruction fields passed from decoder to execute core
`timescale 1ns/10ps
`default_nettype none
interface lwm_dec_if;
  logic [15:0] instr;
  logic isBankLoad;
  logic isLitLoad;
  logic isStore;
  logic accessSel;
  logic [7:0] literal;
  modport decoder (
    input instr,
    output isBankLoad,
    output isLitLoad,
    output isStore,
    output accessSel,
    output literal
  );
  modport core (
    output instr,
    input isBankLoad,
    input isLitLoad,
    input isStore,
    input accessSel,
    input literal
  );
endinterface : lwm_dec_if
`default_nettype wire

// ==== verilog/lwm_decoder.sv ====
// Combinational opcode decoder for the three move instructions
`timescale 1ns/10ps
`default_nettype none
module lwm_decoder (
  lwm_dec_if.decoder dec
);
  // ==========================================================
  // Opcode match
  always_comb begin
    dec.isBankLoad = dec.instr[lwm_pkg::OPC_HI_MSB:lwm_pkg::OPC_HI_LSB]
      == lwm_pkg::OPC_BANK_LOAD;
    dec.isLitLoad = dec.instr[lwm_pkg::OPC_HI_MSB:lwm_pkg::OPC_HI_LSB]
      == lwm_pkg::OPC_LIT_LOAD;
    dec.isStore = dec.instr[lwm_pkg::OPC_HI_MSB:lwm_pkg::OPC_STORE_LSB]
      == lwm_pkg::OPC_STORE;
    dec.accessSel = dec.instr[lwm_pkg::ACCESS_BIT];
    // Any 8-bit file address is legal, so no range check here
    dec.literal = dec.instr[7:0];
  end
endmodule : lwm_decoder
`default_nettype wire

// ==== verilog/lwm_move_exec.sv ====
// Four-phase execute logic for literal and accumulator move instructions
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Upper byte 01h loads bank pointer
// - Bank pointer upper nibble always zero
// - Upper byte 0Eh loads accumulator literal
// - Top bits 0110111 store accumulator to file
// - Store reaches all 256 bank locations
// - Selector zero access bank, one banked
// - Extended mode low access-bank addresses use indexing
module lwm_move_exec (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  output logic instrReady,
  input wire logic extInstrEn,
  output logic [7:0] bankPointer,
  output logic [7:0] accumulator,
  output logic fileWrEn,
  output logic [11:0] fileAddr,
  output logic [7:0] fileWrData,
  output logic fileIndexed,
  output logic statusWrEn,
  output logic cycleDone,
  output logic unknownInstr
);
  lwm_pkg::lwm_phase_t phase_r;
  lwm_pkg::lwm_phase_t phase_nxt;
  logic [15:0] instr_r;
  logic instrLive_r;
  logic [7:0] operand_r;
  logic [7:0] bankPtr_r;
  logic [7:0] accum_r;
  logic [7:0] bankPtr_nxt;
  logic [11:0] addr_r;
  logic [11:0] addr_nxt;
  logic indexed_r;
  logic indexed_nxt;
  logic wrEn_r;
  logic [7:0] wrData_r;
  logic unknown_r;
  logic anyMove;

  lwm_dec_if dec ();

  lwm_decoder uDecoder (
    .dec(dec)
  );

  assign dec.instr = instr_r;
  assign anyMove = dec.isBankLoad | dec.isLitLoad | dec.isStore;

  // ==========================================================
  // Phase sequencer: one instruction cycle is four clocks
  always_comb begin
    unique case (phase_r)
      lwm_pkg::PH_DECODE: phase_nxt = lwm_pkg::PH_READ;
      lwm_pkg::PH_READ: phase_nxt = lwm_pkg::PH_PROCESS;
      lwm_pkg::PH_PROCESS: phase_nxt = lwm_pkg::PH_WRITE;
      lwm_pkg::PH_WRITE: phase_nxt = lwm_pkg::PH_DECODE;
      default: phase_nxt = lwm_pkg::PH_DECODE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_r <= lwm_pkg::PH_DECODE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Words are only taken at the first phase; a word offered later
  // waits, since the previous one still owns the datapath
  assign instrReady = (phase_r == lwm_pkg::PH_DECODE);
  assign cycleDone = (phase_r == lwm_pkg::PH_WRITE) & instrLive_r;

  // ==========================================================
  // Instruction capture
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      instr_r <= lwm_pkg::INSTR_RESET;
      instrLive_r <= 1'b0;
    end else if (phase_r == lwm_pkg::PH_DECODE) begin
      instr_r <= instrWord;
      instrLive_r <= instrValid;
    end
  end

  // ==========================================================
  // Operand read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      operand_r <= 8'h00;
    end else if (phase_r == lwm_pkg::PH_READ) begin
      operand_r <= dec.isStore ? accum_r : dec.literal;
    end
  end

  // ==========================================================
  // Process: destination address and bank value
  always_comb begin
    bankPtr_nxt = {lwm_pkg::BANK_HI_ZERO, operand_r[3:0]};
    indexed_nxt = 1'b0;
    if (dec.accessSel == lwm_pkg::ACCESS_SEL_BANKED) begin
      addr_nxt = {bankPtr_r[3:0], dec.literal};
    end else if (extInstrEn && dec.literal <= lwm_pkg::INDEX_LIMIT) begin
      // Offset only; the external adder supplies the index base
      addr_nxt = {lwm_pkg::ACCESS_LO_PAGE, dec.literal};
      indexed_nxt = 1'b1;
    end else if (dec.literal <= lwm_pkg::INDEX_LIMIT) begin
      addr_nxt = {lwm_pkg::ACCESS_LO_PAGE, dec.literal};
    end else begin
      addr_nxt = {lwm_pkg::ACCESS_HI_PAGE, dec.literal};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_r <= lwm_pkg::ADDR_RESET;
      indexed_r <= 1'b0;
    end else if (phase_r == lwm_pkg::PH_PROCESS && dec.isStore) begin
      addr_r <= addr_nxt;
      indexed_r <= indexed_nxt;
    end
  end

  // ==========================================================
  // Destination write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bankPtr_r <= lwm_pkg::BANK_RESET;
    end else if (phase_r == lwm_pkg::PH_WRITE && instrLive_r
                 && dec.isBankLoad) begin
      bankPtr_r <= bankPtr_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      accum_r <= lwm_pkg::ACCUM_RESET;
    end else if (phase_r == lwm_pkg::PH_WRITE && instrLive_r
                 && dec.isLitLoad) begin
      accum_r <= operand_r;
    end
  end

  // Strobe is registered so it lines up with the write phase output
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrEn_r <= 1'b0;
      wrData_r <= 8'h00;
    end else begin
      wrEn_r <= (phase_r == lwm_pkg::PH_PROCESS) && instrLive_r
        && dec.isStore;
      if (phase_r == lwm_pkg::PH_PROCESS && dec.isStore) begin
        wrData_r <= operand_r;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      unknown_r <= 1'b0;
    end else if (phase_r == lwm_pkg::PH_DECODE) begin
      unknown_r <= 1'b0;
    end else if (phase_r == lwm_pkg::PH_READ) begin
      unknown_r <= instrLive_r & ~anyMove;
    end
  end

  // ==========================================================
  // Outputs
  assign bankPointer = bankPtr_r;
  assign accumulator = accum_r;
  assign fileWrEn = wrEn_r;
  assign fileAddr = addr_r;
  assign fileWrData = wrData_r;
  assign fileIndexed = indexed_r;
  assign statusWrEn = 1'b0;
  assign unknownInstr = unknown_r;
endmodule : lwm_move_exec
`default_nettype wire

// ==== test/lwm_move_exec_assertions.sv ====
// Concurrent checks on the move-instruction execute ports
`timescale 1ns/10ps
`default_nettype none
module lwm_move_exec_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  input wire logic instrReady,
  input wire logic extInstrEn,
  input wire logic [7:0] bankPointer,
  input wire logic [7:0] accumulator,
  input wire logic fileWrEn,
  input wire logic [11:0] fileAddr,
  input wire logic [7:0] fileWrData,
  input wire logic fileIndexed,
  input wire logic statusWrEn,
  input wire logic cycleDone,
  input wire logic unknownInstr
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic take;
  logic isSt;
  assign take = instrReady && instrValid;
  assign isSt = instrWord[15:9] == 7'h37;
  AST_PHASE: assert property (
    instrReady |=> !instrReady [*3] ##1 instrReady)
    else $error("decode phase not one in four");
  AST_BANK_LOAD: assert property (
    take && instrWord[15:8] == 8'h01 |->
      ##4 bankPointer == {4'h0, $past(instrWord[3:0], 4)})
    else $error("bank pointer load wrong");
  AST_BANK_HI: assert property (
    bankPointer[7:4] == 4'h0)
    else $error("bank pointer upper nibble set");
  AST_LIT_LOAD: assert property (
    take && instrWord[15:8] == 8'h0E |->
      ##4 accumulator == $past(instrWord[7:0], 4))
    else $error("accumulator load wrong");
  AST_WR: assert property (
    take |-> ##3 (fileWrEn == $past(isSt, 3)) && cycleDone
      ##1 !fileWrEn)
    else $error("file write pulse wrong");
  AST_DATA: assert property (
    fileWrEn |-> fileWrData == $past(accumulator, 2))
    else $error("stored data wrong");
  AST_BANKED: assert property (
    take && isSt && instrWord[8] |->
      ##3 fileAddr == {bankPointer[3:0], $past(instrWord[7:0], 3)}
      && !fileIndexed)
    else $error("banked address wrong");
  AST_ACCESS: assert property (
    take && isSt && !instrWord[8] |->
      ##3 fileIndexed == ($past(extInstrEn)
        && $past(instrWord[7:0], 3) <= 8'h5F)
      && fileAddr[11:8] ==
        (($past(instrWord[7:0], 3) <= 8'h5F) ? 4'h0 : 4'hF))
    else $error("access bank address wrong");
  AST_STATUS: assert property (
    !statusWrEn)
    else $error("status write seen");
endmodule : lwm_move_exec_chk
bind lwm_move_exec lwm_move_exec_chk u_chk (.sys_clk, .rst, .instrWord,
  .instrValid, .instrReady, .extInstrEn, .bankPointer, .accumulator,
  .fileWrEn, .fileAddr, .fileWrData, .fileIndexed, .statusWrEn,
  .cycleDone, .unknownInstr);
`default_nettype wire

// ==== test/literal_and_w_move_exec_test.sv ====
// Directed testbench for the move-instruction execute logic
`timescale 1ns/10ps
`default_nettype none
module literal_and_w_move_exec_test;
  // ==========================================================
  // Stimulus and checking
  logic sys_clk = 1'b0, rst = 1'b1, instrValid = 1'b0, extInstrEn = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic instrReady, fileWrEn, fileIndexed, statusWrEn, cycleDone, unkI;
  logic [7:0] bankPointer, accumulator, fileWrData, sData, f;
  logic [11:0] fileAddr, sAddr;
  logic sWr, sDone, sIdx, sUnk;
  int mismatches = 0, check_count = 0;
  lwm_move_exec dut (.sys_clk(sys_clk), .rst(rst), .instrWord(instrWord),
    .instrValid(instrValid), .instrReady(instrReady),
    .extInstrEn(extInstrEn), .bankPointer(bankPointer),
    .accumulator(accumulator), .fileWrEn(fileWrEn), .fileAddr(fileAddr),
    .fileWrData(fileWrData), .fileIndexed(fileIndexed),
    .statusWrEn(statusWrEn), .cycleDone(cycleDone), .unknownInstr(unkI));
  always #25 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [11:0] e,
                     input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One instruction; snapshot taken in its write phase
  task automatic run(input logic [15:0] w, input logic v, input logic x);
    int n;
    n = 0;
    while (instrReady !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    instrWord = w;
    instrValid = v;
    extInstrEn = x;
    repeat (3) @(negedge sys_clk);
    instrValid = 1'b0;
    {sWr, sDone, sIdx, sUnk, sAddr, sData} =
      {fileWrEn, cycleDone, fileIndexed, unkI, fileAddr, fileWrData};
    chk("status", 12'h000, {11'h000, statusWrEn});
    @(negedge sys_clk);
  endtask : run
  task automatic t_bank;
    run(16'h01FA, 1'b1, 1'b0);
    chk("bank", 12'h00A, {4'h0, bankPointer});
    chk("done", 12'h001, {11'h000, sDone});
    chk("wr", 12'h000, {11'h000, sWr});
  endtask : t_bank
  task automatic t_store;
    run(16'h0E4F, 1'b1, 1'b0);
    chk("acc", 12'h04F, {4'h0, accumulator});
    run(16'h6FFF, 1'b1, 1'b0);
    chk("wr", 12'h001, {11'h000, sWr});
    chk("addr", 12'hAFF, sAddr);
    chk("data", 12'h04F, {4'h0, sData});
  endtask : t_store
  // Access bank split and indexed mode around the 5Fh boundary
  task automatic t_access;
    for (int i = 0; i < 4; i++) begin
      f = (i[0]) ? 8'h60 : 8'h5F;
      run({8'h6E, f}, 1'b1, i[1]);
      chk("addr", (f <= 8'h5F) ? {4'h0, f} : {4'hF, f}, sAddr);
      chk("idx", {11'h000, i[1] && f <= 8'h5F}, {11'h000, sIdx});
    end
  endtask : t_access
  task automatic t_other;
    run(16'hFFFF, 1'b1, 1'b0);
    chk("unk", 12'h001, {11'h000, sUnk});
    run(16'h0E11, 1'b0, 1'b0);
    chk("acc", 12'h04F, {4'h0, accumulator});
  endtask : t_other
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    t_bank();
    t_store();
    t_access();
    t_other();
    end_of_test();
  end
  // Whole run needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end
endmodule : literal_and_w_move_exec_test
`default_nettype wire
